// File: dpwc_cnt_if.sv
// dpwc_cnt_if.sv: load/expiry pair between the sequencer and its delay counter.
// assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface dpwc_cnt_if;
	logic load;
	logic [7:0] count;
	logic expired;
	modport seq (output load, output count, input expired);
	modport cnt (input load, input count, output expired);
endinterface
`default_nettype wire

// File: dpwc_consts.svh
// dpwc_consts.svh: timing counts and field widths for the dual-port RAM port controller.
// assumes a 25 MHz clk; included by the package and the port controller.
// ----------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------
`ifndef DPWC_CONSTS_SVH
`define DPWC_CONSTS_SVH
`define DPWC_CLK_MHZ 25
`define DPWC_NS_PER_US 1000
`define DPWC_WP_NS 15
`define DPWC_WZ_NS 10
`define DPWC_DW_NS 10
`define DPWC_WH_NS 12
`define DPWC_WDD_NS 50
`define DPWC_DDD_NS 35
`define DPWC_ADDR_W 11
`define DPWC_DATA_W 8
// least times round up to whole cycles and add one, never below two
`define DPWC_CYC_MIN(ns) ((((ns) * `DPWC_CLK_MHZ) + `DPWC_NS_PER_US - 1) / `DPWC_NS_PER_US + 1)
`endif

// File: dpwc_delay.sv
// dpwc_delay.sv: down-counter that flags when a loaded cycle count has elapsed.
// assumes loads come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module dpwc_delay
	import dpwc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_b, // synchronous reset, active low
	dpwc_cnt_if.cnt cif // load and expiry
);
	logic [7:0] cnt_reg;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg <= 8'h00;
		end else if (cif.load) begin
			cnt_reg <= cif.count;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
	assign cif.expired = (cnt_reg == 8'h00) && !cif.load;
endmodule // dpwc_delay
`default_nettype wire

// File: dpwc_monitor.sv
// dpwc_monitor.sv: pin-level checks for the RAM port controller.
// assumes one clock; bound to every dpwc_port_ctrl.
`timescale 1ns/1ps
`default_nettype none
module dpwc_monitor #(
	parameter int ADDR_W = 11
) (
	input wire logic clk, // clock
	input wire logic rst_b, // reset
	input wire logic ramSelN, // select
	input wire logic ramRwN, // read/write
	input wire logic ramOeN, // output enable
	input wire logic [ADDR_W-1:0] ramAddr, // address
	input wire logic ramDataOeN, // data drive
	input wire logic ramBusyN, // busy in
	input wire logic busyOutN, // busy out
	input wire logic rspValid, // done
	input wire logic rspBlocked // blocked
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	addr_hold_a: assert property (!ramSelN && !ramRwN |=> ramSelN || ramRwN || $stable(ramAddr))
		else $error("address moved in write");
	drive_gap_a: assert property (!ramDataOeN |-> ramOeN)
		else $error("data driven with outputs on");
	sel_with_rw_a: assert property (!ramRwN |-> !ramSelN && ramOeN)
		else $error("write strobe without select");
	pulse_min_a: assert property ($fell(ramRwN) |-> !ramRwN [*2])
		else $error("write pulse short");
	end_together_a: assert property ($rose(ramRwN) |-> ramSelN)
		else $error("select outlived write");
	busy_hold_a: assert property ((!ramBusyN && !ramRwN) [*3] ##1 (ramBusyN && !ramRwN)
		|-> !ramRwN [*2]) else $error("write hold cut");
	rsp_pulse_a: assert property (rspValid |=> !rspValid) else $error("done too long");
	blocked_pair_a: assert property (rspBlocked |-> rspValid) else $error("lone blocked");
	master_busy_a: assert property ($past(rst_b) |-> busyOutN) else $error("busy out low");
endmodule // dpwc_monitor
bind dpwc_port_ctrl dpwc_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk, .rst_b, .ramSelN, .ramRwN,
	.ramOeN, .ramAddr, .ramDataOeN, .ramBusyN, .busyOutN, .rspValid, .rspBlocked);
`default_nettype wire

// File: dpwc_pkg.sv
// dpwc_pkg.sv: types for the dual-port RAM port controller.
// assumes dpwc_consts.svh alongside.
`include "dpwc_consts.svh"
package dpwc_pkg;
	typedef enum logic [2:0] {
		DPWC_IDLE = 3'b000,
		DPWC_SETUP = 3'b001,
		DPWC_PULSE = 3'b010,
		DPWC_HOLD = 3'b011,
		DPWC_READ = 3'b100,
		DPWC_DONE = 3'b101
	} dpwc_state_t;
endpackage

// File: dpwc_port_ctrl.sv
// dpwc_port_ctrl.sv: host-side controller for one port of the dual-port static RAM.
// assumes the RAM pins are asynchronous; busy and read data are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "dpwc_consts.svh"
module dpwc_port_ctrl
	import dpwc_pkg::*;
#(
	parameter int ADDR_W = `DPWC_ADDR_W,
	parameter int DATA_W = `DPWC_DATA_W,
	parameter bit SLAVE_PART = 1'b0
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst_b, // synchronous reset, active low
	input wire logic reqValid, // request strobe, one cycle
	input wire logic reqWrite, // 1 write, 0 read
	input wire logic [ADDR_W-1:0] reqAddr, // request address
	input wire logic [DATA_W-1:0] reqData, // write data
	output logic reqReady, // idle, may take a request
	output logic rspValid, // pulse: request finished
	output logic [DATA_W-1:0] rspData, // read data
	output logic rspBlocked, // pulse with rspValid: write saw busy
	output logic ramSelN, // port select, active low
	output logic ramRwN, // read/write, low writes
	output logic ramOeN, // output enable, active low
	output logic [ADDR_W-1:0] ramAddr, // port address
	output logic [DATA_W-1:0] ramDataOut, // data to ram
	output logic ramDataOeN, // data drive enable, low drives
	input wire logic [DATA_W-1:0] ramDataIn, // data from ram pins
	input wire logic ramBusyN, // busy flag from ram, active low
	output logic busyOutN, // busy to a slave partner port, active low
	input wire logic peerWriteN // opposite-port write in progress, active low
);
	// counts are fixed for the 25 MHz clock; another clock rate needs new constants
	localparam logic [7:0] WP_CYC = 8'(`DPWC_CYC_MIN(`DPWC_WP_NS));
	localparam logic [7:0] OFFDW_CYC = 8'(`DPWC_CYC_MIN(`DPWC_WZ_NS + `DPWC_DW_NS));
	localparam logic [7:0] WH_CYC = 8'(`DPWC_CYC_MIN(`DPWC_WH_NS));
	localparam logic [7:0] RD_CYC = 8'(`DPWC_CYC_MIN(`DPWC_WDD_NS));

	dpwc_state_t state_reg, state_next;
	logic writeOp_reg;
	logic blocked_reg;
	logic busyMeta_reg, busySync_reg, peerMeta_reg, peerSync_reg;
	logic [DATA_W-1:0] dinMeta_reg, dinSync_reg;
	dpwc_cnt_if cif ();

	// ----------------------------------------------------------------
	// delay counter
	// ----------------------------------------------------------------
	dpwc_delay u_delay (
		.clk(clk),
		.rst_b(rst_b),
		.cif(cif)
	);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busyMeta_reg <= 1'b1;
			busySync_reg <= 1'b1;
			peerMeta_reg <= 1'b1;
			peerSync_reg <= 1'b1;
			dinMeta_reg <= '0;
			dinSync_reg <= '0;
		end else begin
			// read data crosses two flops as well; the read wait is long enough to cover them
			busyMeta_reg <= ramBusyN;
			busySync_reg <= busyMeta_reg;
			peerMeta_reg <= peerWriteN;
			peerSync_reg <= peerMeta_reg;
			dinMeta_reg <= ramDataIn;
			dinSync_reg <= dinMeta_reg;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cif.load = 1'b0;
		cif.count = 8'h00;
		case (state_reg)
			DPWC_IDLE: begin
				if (reqValid) begin
					state_next = DPWC_SETUP;
				end
			end
			DPWC_SETUP: begin
				// address settles one cycle with select and read/write high
				state_next = writeOp_reg ? DPWC_PULSE : DPWC_READ;
				cif.load = 1'b1;
				// output enable is kept high in writes, so the short pulse suffices
				cif.count = writeOp_reg ? WP_CYC : RD_CYC;
			end
			DPWC_PULSE: begin
				if (!busySync_reg) begin
					// blocked write: hold for the hold time after busy lifts
					cif.load = 1'b1;
					cif.count = WH_CYC;
				end else if (cif.expired) begin
					state_next = DPWC_HOLD;
				end
			end
			DPWC_READ: begin
				// a read blocked by the peer waits until busy lifts and data settles
				if (!busySync_reg) begin
					cif.load = 1'b1;
					cif.count = RD_CYC;
				end else if (cif.expired) begin
					state_next = DPWC_HOLD;
				end
			end
			DPWC_HOLD: begin
				// recovery: strobes already high, address still held
				state_next = DPWC_DONE;
			end
			DPWC_DONE: begin
				state_next = DPWC_IDLE;
			end
			default: begin
				state_next = DPWC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= DPWC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// request capture and address/data pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			writeOp_reg <= 1'b0;
			ramAddr <= '0;
			ramDataOut <= '0;
		end else if (state_reg == DPWC_IDLE && reqValid) begin
			// address moves only while both strobes are high
			writeOp_reg <= reqWrite;
			ramAddr <= reqAddr;
			ramDataOut <= reqData;
		end
	end

	// ----------------------------------------------------------------
	// strobes
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ramSelN <= 1'b1;
			ramRwN <= 1'b1;
			ramOeN <= 1'b1;
			ramDataOeN <= 1'b1;
		end else begin
			// read/write and select fall together, so ram outputs stay off
			ramRwN <= !(state_next == DPWC_PULSE);
			ramSelN <= !(state_next == DPWC_PULSE || state_next == DPWC_READ);
			// output enable stays high while writing
			ramOeN <= !(state_next == DPWC_READ);
			ramDataOeN <= !(state_next == DPWC_PULSE);
		end
	end

	// ----------------------------------------------------------------
	// busy to a slave partner: the opposite port's write, while this port is not idle
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busyOutN <= 1'b1;
		end else if (SLAVE_PART) begin
			// drive busy from the cycle after SETUP, with the start of the write or read; same on either port
			// limitation: two slave-mode ports that start together block each other
			busyOutN <= peerSync_reg || (state_reg == DPWC_IDLE);
		end else begin
			busyOutN <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// answers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			blocked_reg <= 1'b0;
		end else if (state_reg == DPWC_SETUP) begin
			blocked_reg <= 1'b0;
		end else if (state_reg == DPWC_PULSE && !busySync_reg) begin
			blocked_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rspValid <= 1'b0;
			rspBlocked <= 1'b0;
			reqReady <= 1'b0;
		end else begin
			rspValid <= (state_reg == DPWC_DONE);
			rspBlocked <= (state_reg == DPWC_DONE) && blocked_reg;
			reqReady <= (state_next == DPWC_IDLE) && !(state_reg == DPWC_IDLE && reqValid);
		end
	end

	// read data stands until the next read ends, so it is valid from rspValid onwards
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rspData <= '0;
		end else if (state_reg == DPWC_READ && cif.expired && busySync_reg) begin
			// the other port's write is visible after the port-to-port delay
			rspData <= dinSync_reg;
		end
	end
endmodule // dpwc_port_ctrl
`default_nettype wire

// File: dpwc_ram_model.sv
// dpwc_ram_model.sv: behavioural master RAM port seen by the controller.
// assumes pins sampled on clk; the peer port is abstracted by peerOn/peerAddr.
`timescale 1ns/1ps
`default_nettype none
module dpwc_ram_model (
	input wire logic clk, // clock
	input wire logic selN, // select
	input wire logic rwN, // read/write
	input wire logic oeN, // output enable
	input wire logic [10:0] addr, // address
	input wire logic [7:0] dIn, // data from host
	input wire logic dOeN, // host drives data
	output logic [7:0] dOut, // data to host
	output logic busyN, // busy flag
	input wire logic peerOn, // peer settled first on peerAddr
	input wire logic [10:0] peerAddr // peer address
);
	logic [7:0] mem [2048];
	logic [7:0] lastOut = 8'h00;
	// peer was stable first, so this port loses; peer flag never shown
	assign busyN = !(peerOn && !selN && peerAddr == addr);
	always @(posedge clk) if (!selN && !rwN && busyN && !dOeN) mem[addr] <= dIn;
	// released bus shows a moving pattern, not a held value
	assign dOut = (!selN && !oeN && rwN) ? mem[addr] : ~lastOut;
	always @(posedge clk) lastOut <= dOut;
endmodule // dpwc_ram_model
`default_nettype wire

// File: tb_top.sv
// tb_top.sv: random and corner writes, read-backs and a busy contention.
// assumes the master RAM model and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, rst_b = 0, reqValid = 0, reqWrite = 0, peerOn = 0, peerWriteN = 1;
	logic [10:0] reqAddr = 0, ramAddr, peerAddr = 0;
	logic [7:0] reqData = 0, rspData, ramDataOut, ramDataIn, shadow [2048];
	logic reqReady, rspValid, rspBlocked, ramSelN, ramRwN, ramOeN, ramDataOeN, ramBusyN;
	logic busyOutN;
	int nErrors = 0, nTests = 0, cycles = 0;
	dpwc_port_ctrl dut_u (.clk, .rst_b, .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady,
		.rspValid, .rspData, .rspBlocked, .ramSelN, .ramRwN, .ramOeN, .ramAddr, .ramDataOut,
		.ramDataOeN, .ramDataIn, .ramBusyN, .busyOutN, .peerWriteN);
	dpwc_ram_model ram_u (.clk, .selN(ramSelN), .rwN(ramRwN), .oeN(ramOeN), .addr(ramAddr),
		.dIn(ramDataOut), .dOeN(ramDataOeN), .dOut(ramDataIn), .busyN(ramBusyN), .peerOn,
		.peerAddr);
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			nErrors++;
			printVerdict;
		end
	end
	function automatic logic [7:0] expRead(input logic [10:0] a);
		return shadow[a];
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// waits are cut short by the cycle ceiling above
	task automatic do_op(input logic wr, input logic [10:0] a, input logic [7:0] d);
		do @(negedge clk); while (reqReady !== 1'b1);
		@(posedge clk);
		reqValid <= 1;
		reqWrite <= wr;
		reqAddr <= a;
		reqData <= d;
		@(posedge clk);
		reqValid <= 0;
		do @(negedge clk); while (rspValid !== 1'b1);
	endtask
	task automatic printVerdict;
		$display("tests %0d errors %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		logic [10:0] a;
		logic [7:0] d;
		void'($urandom(32'hDEA57AAD));
		repeat (6) @(posedge clk);
		rst_b <= 1;
		// first two passes hit the lowest and highest address
		for (int i = 0; i < 24; i++) begin
			a = (i < 2) ? {11{i[0]}} : 11'($urandom);
			d = 8'($urandom);
			do_op(1, a, d);
			check({7'h00, rspBlocked}, 8'h00);
			shadow[a] = d;
			do_op(0, a, 8'h00);
			check(rspData, expRead(a));
		end
		a = 11'h2A5;
		@(posedge clk);
		peerAddr <= a;
		peerOn <= 1;
		peerWriteN <= 0;
		fork
			do_op(1, a, 8'h5C);
			begin
				repeat (9) @(posedge clk);
				@(negedge clk);
				// master mode arbitrates inside the ram, so no busy goes to the peer
				check({7'h00, busyOutN}, 8'h01);
				@(posedge clk);
				peerOn <= 0;
				peerWriteN <= 1;
			end
		join
		check({7'h00, rspBlocked}, 8'h01);
		shadow[a] = 8'h5C;
		do_op(0, a, 8'h00);
		check(rspData, expRead(a));
		printVerdict;
	end
endmodule // tb_top
`default_nettype wire
